// File: shared/tcc_pkg.sv
// Package: register map, field layout and timing counts of the capture/compare timer
package tcc_pkg;
    // ========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_CONTROL = 6'h12;
    localparam logic [5:0] IDX_FLAGS = 6'h13;
    localparam logic [5:0] IDX_CAP_HI = 6'h14;
    localparam logic [5:0] IDX_CAP_LO = 6'h15;
    localparam logic [5:0] IDX_CMP_HI = 6'h16;
    localparam logic [5:0] IDX_CMP_LO = 6'h17;
    localparam logic [5:0] IDX_CNT_HI = 6'h18;
    localparam logic [5:0] IDX_CNT_LO = 6'h19;
    // ========================================================
    // Timing
    localparam int TICK_DIV = 4;
    localparam int COUNT_WRAP = 65536;
    localparam int FULL_CYCLE = COUNT_WRAP * TICK_DIV;
    localparam logic [1:0] PRESC_LAST = 2'(TICK_DIV - 1);
    localparam logic [1:0] PRESC_CMP = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // ========================================================
    // Field layouts and reset values
    typedef struct packed {
        logic cap_irq_enable;
        logic compare_irq_enable;
        logic ovf_irq_enable;
        logic [2:0] reserved;
        logic capture_edge_select;
        logic compare_output_level;
    } tcc_control_t;
    typedef struct packed {
        logic capture_flag;
        logic compare_flag;
        logic overflow_flag;
        logic [4:0] reserved;
    } tcc_flags_t;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcc_pkg

// File: design/tcc_timer.sv
// Capture/compare timer with free-running counter behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module tcc_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins and request
    input wire logic capture_input_pin,
    output logic compare_output_pin,
    output logic timer_irq
);

    // ========================================================
    // Decoding
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        reg_index = addr[7:2];
    endfunction : reg_index

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx >= tcc_pkg::IDX_CONTROL) && (idx <= tcc_pkg::IDX_CNT_LO);
    endfunction : is_mapped

    // ========================================================
    // State
    logic [1:0] presc;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] compare;
    logic compare_inhibit;
    tcc_pkg::tcc_control_t ctl;
    logic capture_flag;
    logic compare_flag;
    logic overflow_flag;
    logic cap_arm;
    logic cmp_arm;
    logic ovf_arm;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [5:0] aw_idx;
    logic aw_full;
    logic [7:0] w_byte;
    logic w_lane;
    logic w_full;
    logic tick;
    logic cap_edge;
    logic match;
    logic wr_fire;
    logic rd_fire;
    logic [5:0] rd_idx;
    logic [7:0] next_rbyte;
    tcc_pkg::tcc_flags_t flags_view;

    // ========================================================
    // Prescaler and counter
    assign tick = (presc == tcc_pkg::PRESC_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= 2'h0;
            count <= tcc_pkg::COUNT_RESET;
        end else begin
            presc <= presc + 2'h1;
            if (tick) begin
                count <= count + 16'h1;
            end
        end
    end

    // ========================================================
    // Capture path
    // Second and third stages feed the edge detector, the first is never looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= capture_input_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign cap_edge = ctl.capture_edge_select ? (sync_b && !sync_c) : (!sync_b && sync_c);

    // No reset branch: the latch survives reset
    always_ff @(posedge aclk) begin
        if (cap_edge) begin
            capture <= count;
        end
    end

    // ========================================================
    // Compare path
    assign match = (presc == tcc_pkg::PRESC_CMP) && !compare_inhibit && (compare == count);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_output_pin <= 1'b0;
        end else if (match) begin
            compare_output_pin <= ctl.compare_output_level;
        end
    end

    // ========================================================
    // Bus channels
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = reg_index(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_idx <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_idx <= reg_index(s_axi_awaddr);
        end else if (wr_fire) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tcc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_idx) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================
    // Register writes
    logic wr_ok;
    assign wr_ok = wr_fire && w_lane;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= tcc_pkg::CONTROL_RESET;
        end else if (wr_ok && aw_idx == tcc_pkg::IDX_CONTROL) begin
            ctl <= {w_byte[7:5], 3'h0, w_byte[1:0]};
        end
    end

    // Compare value is kept through reset
    always_ff @(posedge aclk) begin
        if (wr_ok && aw_idx == tcc_pkg::IDX_CMP_HI) begin
            compare[15:8] <= w_byte;
        end
        if (wr_ok && aw_idx == tcc_pkg::IDX_CMP_LO) begin
            compare[7:0] <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_inhibit <= 1'b0;
        end else if (wr_ok && aw_idx == tcc_pkg::IDX_CMP_HI) begin
            compare_inhibit <= 1'b1;
        end else if (wr_ok && aw_idx == tcc_pkg::IDX_CMP_LO) begin
            compare_inhibit <= 1'b0;
        end
    end

    // ========================================================
    // Reads
    assign flags_view = '{capture_flag: capture_flag, compare_flag: compare_flag,
                          overflow_flag: overflow_flag, reserved: 5'h00};

    always_comb begin
        next_rbyte = 8'h00;
        unique case (rd_idx)
            tcc_pkg::IDX_CONTROL: next_rbyte = ctl;
            tcc_pkg::IDX_FLAGS: next_rbyte = flags_view;
            tcc_pkg::IDX_CAP_HI: next_rbyte = capture[15:8];
            tcc_pkg::IDX_CAP_LO: next_rbyte = capture[7:0];
            tcc_pkg::IDX_CMP_HI: next_rbyte = compare[15:8];
            tcc_pkg::IDX_CMP_LO: next_rbyte = compare[7:0];
            tcc_pkg::IDX_CNT_HI: next_rbyte = count[15:8];
            tcc_pkg::IDX_CNT_LO: next_rbyte = count[7:0];
            default: next_rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tcc_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, next_rbyte};
            s_axi_rresp <= is_mapped(rd_idx) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================
    // Flags and their two-step clear
    logic flags_rd;
    logic clr_cap;
    logic clr_cmp;
    logic clr_ovf;
    logic ovf_set;
    assign flags_rd = rd_fire && rd_idx == tcc_pkg::IDX_FLAGS;
    assign clr_cap = cap_arm && rd_fire && rd_idx == tcc_pkg::IDX_CAP_LO;
    assign clr_cmp = cmp_arm && ((rd_fire && rd_idx == tcc_pkg::IDX_CMP_LO)
                     || (wr_ok && aw_idx == tcc_pkg::IDX_CMP_LO));
    assign clr_ovf = ovf_arm && rd_fire && rd_idx == tcc_pkg::IDX_CNT_LO;
    assign ovf_set = tick && (count == tcc_pkg::COUNT_MAX);

    // Arm only once the flag was seen set; a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_flag <= 1'b0;
            cap_arm <= 1'b0;
        end else begin
            capture_flag <= cap_edge || (capture_flag && !clr_cap);
            cap_arm <= (flags_rd && capture_flag) || (cap_arm && !clr_cap);
        end
    end

    // Compare flag is kept through reset; only its arm is cleared
    always_ff @(posedge aclk) begin
        compare_flag <= match || (compare_flag && !clr_cmp);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_arm <= 1'b0;
        end else begin
            cmp_arm <= (flags_rd && compare_flag) || (cmp_arm && !clr_cmp);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
            ovf_arm <= 1'b0;
        end else begin
            overflow_flag <= ovf_set || (overflow_flag && !clr_ovf);
            ovf_arm <= (flags_rd && overflow_flag) || (ovf_arm && !clr_ovf);
        end
    end

    assign timer_irq = (capture_flag && ctl.cap_irq_enable) || (compare_flag && ctl.compare_irq_enable)
                       || (overflow_flag && ctl.ovf_irq_enable);

    // ========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tick_period: assert property (tick |=> !tick [*3] ##1 tick) else $error("tick spacing wrong");
    a_count_step: assert property (tick |=> count == $past(count) + 16'h1) else $error("count step wrong");
    a_count_hold: assert property (!tick |=> $stable(count)) else $error("count moved off tick");
    a_capture_load: assert property (cap_edge |=> capture == $past(count) && capture_flag)
        else $error("capture not loaded");
    a_sync_lag: assert property ($rose(sync_b) && ctl.capture_edge_select |-> cap_edge)
        else $error("rising edge missed");
    a_cmp_pin: assert property (match |=> compare_output_pin == $past(ctl.compare_output_level) && compare_flag)
        else $error("compare pin wrong");
    a_cmp_inhibit: assert property (compare_inhibit |-> !match) else $error("match while inhibited");
    a_ovf_set: assert property (ovf_set |=> overflow_flag && count == tcc_pkg::COUNT_RESET)
        else $error("overflow not flagged");
    a_flag_clear: assert property ($fell(capture_flag) |-> $past(cap_arm)) else $error("capture flag cleared early");
    a_irq_gate: assert property (!ctl.compare_irq_enable && !ctl.cap_irq_enable && !ctl.ovf_irq_enable |-> !timer_irq)
        else $error("irq without enable");
    a_pin_reset: assert property (disable iff (1'b0) !aresetn |=> !compare_output_pin)
        else $error("pin not low in reset");

    c_capture: cover property (cap_edge ##1 capture_flag);
    c_match: cover property (match && ctl.compare_output_level);
    c_overflow: cover property (ovf_set);
    c_clear: cover property (clr_cmp && !match);

endmodule : tcc_timer

`default_nettype wire

// File: verification/tcc_pin_model.sv
// Pin model: source on the capture pin, load on the compare pin
`timescale 1ns/10ps
`default_nettype none
// ====================
// Pin model
module tcc_pin_model #(
    parameter real SKEW = 1.7
) (
    // Request from the bench
    input wire logic level_req,
    // Timer pins
    input wire logic compare_output_pin,
    output logic capture_input_pin,
    output logic [7:0] compare_rises
);
    initial capture_input_pin = 1'b0;
    initial compare_rises = 8'h00;
    // Skewed off the clock so the synchroniser sees a truly async edge
    always @(level_req) capture_input_pin <= #(SKEW) level_req;
    always @(posedge compare_output_pin) compare_rises <= compare_rises + 8'h01;
endmodule : tcc_pin_model
`default_nettype wire

// File: verification/tb.sv
// Testbench: register, compare, capture and reset scenarios of the timer
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench top
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, level_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cap_pin, cmp_pin, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [7:0] rises, d;
    logic [15:0] t, v, e;
    int miscompares = 0, checks = 0, cyc = 0;

    always #2.5 aclk = ~aclk;
    // Clocks since release; four of them make one counter tick
    always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

    tcc_timer tcc_timer_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .capture_input_pin(cap_pin), .compare_output_pin(cmp_pin), .timer_irq(irq));
    tcc_pin_model tcc_pin_model_inst (.level_req(level_req), .compare_output_pin(cmp_pin),
        .capture_input_pin(cap_pin), .compare_rises(rises));

    // ====================
    // Reporting
    task report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task timeout;
        miscompares++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop;
    endtask : timeout
    // ====================
    // Bus and pin helpers
    task wr(input logic [5:0] idx, input logic [7:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h000000, data};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        if (n >= 50) timeout;
        resp = bresp;
        bready <= 1'b0;
        // Let an edge pass so the next call never drives bready twice in one step
        @(posedge aclk);
    endtask : wr
    task rd(input logic [5:0] idx, output logic [7:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        if (n >= 50) timeout;
        data = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task wait_pin(input logic lvl);
        int n;
        n = 0;
        while (cmp_pin !== lvl && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 1000) timeout;
    endtask : wait_pin
    // High byte first keeps a half-written value from matching
    task set_cmp(input logic [15:0] val);
        wr(tcc_pkg::IDX_CMP_HI, val[15:8], r);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        wr(tcc_pkg::IDX_CMP_LO, val[7:0], r);
    endtask : set_cmp
    task cap_read;
        rd(tcc_pkg::IDX_CAP_HI, v[15:8], r);
        rd(tcc_pkg::IDX_CAP_LO, v[7:0], r);
    endtask : cap_read
    // ====================
    // Scenarios
    task s_regs;
        rd(tcc_pkg::IDX_CONTROL, d, r);
        check(d, tcc_pkg::CONTROL_RESET);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'hA0, 8'h00);
        rd(6'h00, d, r);
        check(8'(r), 8'(tcc_pkg::RESP_SLVERR));
        wr(6'h3F, 8'h5A, r);
        check(8'(r), 8'(tcc_pkg::RESP_SLVERR));
        wr(tcc_pkg::IDX_FLAGS, 8'hFF, r);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'hA0, 8'h00);
        wr(tcc_pkg::IDX_CONTROL, 8'hFF, r);
        rd(tcc_pkg::IDX_CONTROL, d, r);
        check(d, 8'hE3);
        rd(tcc_pkg::IDX_CNT_LO, d, r);
        check(8'((8'(cyc >> 2) - d) <= 8'h02), 8'h01);
    endtask : s_regs
    task s_compare;
        wr(tcc_pkg::IDX_CONTROL, 8'h41, r);
        t = 16'((cyc >> 2) + 60);
        set_cmp(t);
        rd(tcc_pkg::IDX_CMP_HI, d, r);
        check(d, t[15:8]);
        wait_pin(1'b1);
        check(rises, 8'h01);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h40, 8'h40);
        check(8'(irq), 8'h01);
        rd(tcc_pkg::IDX_CMP_LO, d, r);
        check(d, t[7:0]);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h40, 8'h00);
        check(8'(irq), 8'h00);
        wr(tcc_pkg::IDX_CONTROL, 8'h00, r);
        set_cmp(16'((cyc >> 2) + 60));
        check(8'(cmp_pin), 8'h01);
        wait_pin(1'b0);
        check(8'(irq), 8'h00);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h40, 8'h40);
    endtask : s_compare
    task s_inhibit;
        wr(tcc_pkg::IDX_CONTROL, 8'h01, r);
        t = 16'((cyc >> 2) + 40);
        set_cmp(t);
        wr(tcc_pkg::IDX_CMP_HI, t[15:8], r);
        repeat (400) @(posedge aclk);
        check(8'(cmp_pin), 8'h00);
        t = 16'((cyc >> 2) + 40);
        set_cmp(t);
        wait_pin(1'b1);
    endtask : s_inhibit
    task s_capture;
        wr(tcc_pkg::IDX_CONTROL, 8'h82, r);
        e = 16'(cyc >> 2);
        level_req <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h80, 8'h80);
        check(8'(irq), 8'h01);
        cap_read;
        check(8'(16'(v - e) <= 16'h0003), 8'h01);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h80, 8'h00);
        check(8'(irq), 8'h00);
        level_req <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h80, 8'h00);
        wr(tcc_pkg::IDX_CONTROL, 8'h00, r);
        level_req <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h80, 8'h00);
        for (int i = 0; i < 2; i++) begin
            t = v;
            level_req <= 1'b0;
            repeat (10) @(posedge aclk);
            cap_read;
            check(8'(v > t), 8'h01);
            level_req <= 1'b1;
            repeat (10) @(posedge aclk);
        end
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'h80, 8'h80);
        check(8'(irq), 8'h00);
    endtask : s_capture
    task s_reset_keep;
        e = v;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        check(8'(cmp_pin), 8'h00);
        aresetn <= 1'b1;
        @(posedge aclk);
        cap_read;
        check(v[15:8], e[15:8]);
        check(v[7:0], e[7:0]);
        rd(tcc_pkg::IDX_FLAGS, d, r);
        check(d & 8'hE0, 8'h40);
        rd(tcc_pkg::IDX_CMP_LO, d, r);
        check(d, t[7:0]);
    endtask : s_reset_keep
    // ====================
    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        check(8'(cmp_pin), 8'h00);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_regs;
        s_compare;
        s_inhibit;
        s_capture;
        // Drive the pin high and set the compare flag so reset has something to clear (the pin) and to keep (the flag)
        wr(tcc_pkg::IDX_CONTROL, 8'h01, r);
        t = 16'((cyc >> 2) + 200);
        set_cmp(t);
        repeat (900) @(posedge aclk);
        check(8'(cmp_pin), 8'h01);
        s_reset_keep;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
